/* File: rtl/ctc_top.sv */
`timescale 1ns/1ps
`include "ctc_cfg.svh"
module ctc_top
(
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    // Parallel register bus
    input wire logic [3:0] BUS_ADDR_I,
    input wire logic BUS_WR_I,
    input wire logic [7:0] BUS_WDATA_I,
    output logic [7:0] BUS_RDATA_O,
    // UART side events
    input wire logic ETU_TICK_I,
    input wire logic START_BIT_I,
    input wire logic RECEIVE_DIRECTION_I,
    input wire logic CARD_ACTIVE_I,
    // Timeout results
    output logic LOW_TIMEOUT_O,
    output logic HIGH_TIMEOUT_O,
    output logic TIMEOUT_IRQ_O
);
    // ==========================================
    // Configuration decode
    function automatic ctc_pkg::ctc_cfg_t decode(input logic [7:0] code);
        ctc_pkg::ctc_cfg_t c;
        // Fields: wide, upper mode, low mode, low auto-stop, upper auto-stop
        case (code)
            `CTC_CODE_L_SB: c = '{1'b0, ctc_pkg::CTC_OFF, ctc_pkg::CTC_SB_RELOAD, 1'b0, 1'b0};
            `CTC_CODE_H_SW: c = '{1'b0, ctc_pkg::CTC_SW, ctc_pkg::CTC_OFF, 1'b0, 1'b0};
            `CTC_CODE_HSW_LSB: c = '{1'b0, ctc_pkg::CTC_SW, ctc_pkg::CTC_SB_RELOAD, 1'b0, 1'b0};
            `CTC_CODE_W_SW: c = '{1'b1, ctc_pkg::CTC_SW, ctc_pkg::CTC_OFF, 1'b0, 1'b0};
            `CTC_CODE_H_SB: c = '{1'b0, ctc_pkg::CTC_SB, ctc_pkg::CTC_OFF, 1'b0, 1'b0};
            `CTC_CODE_HSB_LSB: c = '{1'b0, ctc_pkg::CTC_SB, ctc_pkg::CTC_SB_RELOAD, 1'b0, 1'b0};
            `CTC_CODE_W_SB: c = '{1'b1, ctc_pkg::CTC_SB, ctc_pkg::CTC_OFF, 1'b0, 1'b0};
            `CTC_CODE_L_AS: c = '{1'b0, ctc_pkg::CTC_OFF, ctc_pkg::CTC_SB_RELOAD, 1'b1, 1'b0};
            `CTC_CODE_HSW_LAS: c = '{1'b0, ctc_pkg::CTC_SW, ctc_pkg::CTC_SB_RELOAD, 1'b1, 1'b0};
            `CTC_CODE_HAS: c = '{1'b0, ctc_pkg::CTC_SB, ctc_pkg::CTC_OFF, 1'b0, 1'b1};
            `CTC_CODE_HAS_LAS: c = '{1'b0, ctc_pkg::CTC_SB, ctc_pkg::CTC_SB_RELOAD, 1'b1, 1'b1};
            default: c = '{1'b0, ctc_pkg::CTC_OFF, ctc_pkg::CTC_OFF, 1'b0, 1'b0};
        endcase
        return c;
    endfunction

    // ==========================================
    // Input synchronisers for the card I/O start detect and status
    ctc_pkg::ctc_evt_t evt_meta_reg;
    ctc_pkg::ctc_evt_t evt_reg;
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            evt_meta_reg <= '0;
            evt_reg <= '0;
        end
        else
        begin
            evt_meta_reg <= '{ETU_TICK_I, START_BIT_I, RECEIVE_DIRECTION_I, CARD_ACTIVE_I};
            evt_reg <= evt_meta_reg;
        end
    end
    logic tick, sbit;
    assign tick = evt_reg.etu_tick && evt_reg.card_active;
    assign sbit = evt_reg.start_bit && evt_reg.card_active;
    // ==========================================
    // Register file
    logic [7:0] mode_reg, rld_high_reg, rld_mid_reg, rld_low_reg;
    logic mode_wr;
    assign mode_wr = BUS_WR_I && (BUS_ADDR_I == `CTC_ADDR_MODE);
    // Host writes; low reload honoured only by host discipline
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            mode_reg <= `CTC_RST_BYTE;
            rld_high_reg <= `CTC_RST_BYTE;
            rld_mid_reg <= `CTC_RST_BYTE;
            rld_low_reg <= `CTC_RST_BYTE;
        end
        else if (BUS_WR_I)
        begin
            case (BUS_ADDR_I)
                `CTC_ADDR_MODE: mode_reg <= BUS_WDATA_I;
                `CTC_ADDR_RLD_HIGH: rld_high_reg <= BUS_WDATA_I;
                `CTC_ADDR_RLD_MID: rld_mid_reg <= BUS_WDATA_I;
                `CTC_ADDR_RLD_LOW: rld_low_reg <= BUS_WDATA_I;
                default: ;
            endcase
        end
    end
    ctc_pkg::ctc_cfg_t cfg, new_cfg;
    assign cfg = decode(mode_reg);
    assign new_cfg = decode(BUS_WDATA_I);
    // ==========================================
    // Counters: upper pair, optional low stage joined in wide mode
    logic [15:0] high_cnt_reg;
    logic [7:0] low_cnt_reg;
    logic [23:0] wide_cnt;
    logic high_run_reg, low_run_reg, high_tc, low_tc, low_expire, high_expire, sw_start;
    assign wide_cnt = {high_cnt_reg, low_cnt_reg};
    assign high_tc = high_run_reg && tick &&
        (cfg.wide ? (wide_cnt == `CTC_ONE24) : (high_cnt_reg == `CTC_ONE16));
    assign low_tc = low_run_reg && tick && (low_cnt_reg == `CTC_ONE8);
    // A compatible software code written mid-count does not restart it
    assign sw_start = mode_wr && (new_cfg.high_mode == ctc_pkg::CTC_SW) &&
        !(high_run_reg && cfg.high_mode == ctc_pkg::CTC_SW && new_cfg.wide == cfg.wide);

    ctc_astop u_low_astop
    (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .arm_i(cfg.low_astop_rx && evt_reg.receive_direction),
        .start_i(sbit),
        .tick_i(tick),
        .expire_o(low_expire)
    );
    ctc_astop u_high_astop
    (
        .clk_i(CORE_CLK_I),
        .rst_i(RESET_I),
        .arm_i(cfg.high_astop_rx && evt_reg.receive_direction),
        .start_i(sbit),
        .tick_i(tick),
        .expire_o(high_expire)
    );

    // Upper (or wide) counter
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            high_cnt_reg <= `CTC_ZERO16;
            high_run_reg <= 1'b0;
        end
        else if (mode_wr && new_cfg.high_mode == ctc_pkg::CTC_OFF)
            high_run_reg <= 1'b0;
        else if (sw_start)
        begin
            high_cnt_reg <= {rld_high_reg, rld_mid_reg};
            high_run_reg <= 1'b1;
        end
        else if (cfg.high_mode == ctc_pkg::CTC_SB && sbit && !high_expire)
        begin
            high_cnt_reg <= {rld_high_reg, rld_mid_reg};
            high_run_reg <= 1'b1;
        end
        else if (high_tc || high_expire)
            high_run_reg <= 1'b0;
        else if (high_run_reg && tick)
        begin
            if (cfg.wide)
                high_cnt_reg <= wide_cnt[23:8] - {15'h0000, (low_cnt_reg == `CTC_ZERO8)};
            else
                high_cnt_reg <= high_cnt_reg - `CTC_ONE16;
        end
    end

    // Low stage: own 8-bit counter, or low byte of the wide counter
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            low_cnt_reg <= `CTC_ZERO8;
            low_run_reg <= 1'b0;
        end
        else if (cfg.wide || (mode_wr && new_cfg.wide))
        begin
            low_run_reg <= 1'b0;
            if (sw_start || (cfg.high_mode == ctc_pkg::CTC_SB && sbit))
                low_cnt_reg <= rld_low_reg;
            else if (high_run_reg && tick && !high_tc)
                low_cnt_reg <= low_cnt_reg - `CTC_ONE8;
        end
        else if (mode_wr && new_cfg.low_mode == ctc_pkg::CTC_OFF)
            low_run_reg <= 1'b0;
        else if (cfg.low_mode == ctc_pkg::CTC_SB_RELOAD && sbit && !low_run_reg && !low_expire)
        begin
            low_cnt_reg <= rld_low_reg;
            low_run_reg <= 1'b1;
        end
        else if (low_expire)
            low_run_reg <= 1'b0;
        else if (low_tc)
            low_cnt_reg <= rld_low_reg;
        else if (low_run_reg && tick)
            low_cnt_reg <= low_cnt_reg - `CTC_ONE8;
    end

    // ==========================================
    // Timeout flags, cleared by writing ones to the status register; a read does not clear them
    logic clr_wr;
    assign clr_wr = BUS_WR_I && (BUS_ADDR_I == `CTC_ADDR_STATUS);
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
        begin
            LOW_TIMEOUT_O <= 1'b0;
            HIGH_TIMEOUT_O <= 1'b0;
            TIMEOUT_IRQ_O <= 1'b0;
        end
        else
        begin
            // Set wins over clear so no terminal count is lost
            LOW_TIMEOUT_O <= low_tc || (LOW_TIMEOUT_O && !(clr_wr && BUS_WDATA_I[`CTC_CLR_LOW_BIT]));
            HIGH_TIMEOUT_O <= high_tc || (HIGH_TIMEOUT_O && !(clr_wr && BUS_WDATA_I[`CTC_CLR_HIGH_BIT]));
            TIMEOUT_IRQ_O <= low_tc || high_tc ||
                ((LOW_TIMEOUT_O && !(clr_wr && BUS_WDATA_I[`CTC_CLR_LOW_BIT])) ||
                 (HIGH_TIMEOUT_O && !(clr_wr && BUS_WDATA_I[`CTC_CLR_HIGH_BIT])));
        end
    end

    // Registered read data
    always_ff @(posedge CORE_CLK_I)
    begin
        if (RESET_I)
            BUS_RDATA_O <= `CTC_RST_BYTE;
        else
        begin
            case (BUS_ADDR_I)
                `CTC_ADDR_MODE: BUS_RDATA_O <= mode_reg;
                `CTC_ADDR_RLD_HIGH: BUS_RDATA_O <= rld_high_reg;
                `CTC_ADDR_RLD_MID: BUS_RDATA_O <= rld_mid_reg;
                `CTC_ADDR_RLD_LOW: BUS_RDATA_O <= rld_low_reg;
                `CTC_ADDR_STATUS: BUS_RDATA_O <= {4'h0, high_run_reg, low_run_reg, HIGH_TIMEOUT_O, LOW_TIMEOUT_O};
                default: BUS_RDATA_O <= `CTC_RST_BYTE;
            endcase
        end
    end

    // ==========================================
    // Checks
    sequence s_high_tc;
        high_tc;
    endsequence
    property p_tc_flag;
        @(posedge CORE_CLK_I) disable iff (RESET_I) s_high_tc |=> HIGH_TIMEOUT_O && TIMEOUT_IRQ_O;
    endproperty
    a_tc_flag: assert property (p_tc_flag) else $error("high flag not set");
    property p_low_flag;
        @(posedge CORE_CLK_I) disable iff (RESET_I) low_tc |=> LOW_TIMEOUT_O;
    endproperty
    a_low_flag: assert property (p_low_flag) else $error("low flag not set");
    property p_stop_all;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        mode_wr && BUS_WDATA_I == `CTC_CODE_STOP |=> !high_run_reg && !low_run_reg;
    endproperty
    a_stop_all: assert property (p_stop_all) else $error("stop code left a counter running");
    property p_wide_stop;
        @(posedge CORE_CLK_I) disable iff (RESET_I) high_tc && !sbit && !mode_wr |=> !high_run_reg;
    endproperty
    a_wide_stop: assert property (p_wide_stop) else $error("wide counter kept running");
    property p_low_reload;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        low_tc && !mode_wr && !low_expire |=> low_run_reg && low_cnt_reg == $past(rld_low_reg);
    endproperty
    a_low_reload: assert property (p_low_reload) else $error("low stage did not reload");
    property p_no_tick;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        !tick && !sbit && !mode_wr |=> $stable(high_cnt_reg);
    endproperty
    a_no_tick: assert property (p_no_tick) else $error("count moved without a tick");
    property p_sb_load;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        cfg.high_mode == ctc_pkg::CTC_SB && sbit && !mode_wr && !high_expire
        |=> high_run_reg && high_cnt_reg == {$past(rld_high_reg), $past(rld_mid_reg)};
    endproperty
    a_sb_load: assert property (p_sb_load) else $error("start bit did not load");
    property p_unknown;
        @(posedge CORE_CLK_I) disable iff (RESET_I)
        mode_wr && new_cfg.high_mode == ctc_pkg::CTC_OFF && new_cfg.low_mode == ctc_pkg::CTC_OFF
        |=> !high_run_reg && !low_run_reg;
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown code did not stop");
endmodule // ctc_top

/* File: pkg/ctc_cfg.svh */
`ifndef CTC_CFG_SVH
`define CTC_CFG_SVH
// ==========================================
// Register offsets on the parallel bus (local choice, 4-bit address)
`define CTC_ADDR_MODE 4'h0
`define CTC_ADDR_RLD_HIGH 4'h1
`define CTC_ADDR_RLD_MID 4'h2
`define CTC_ADDR_RLD_LOW 4'h3
`define CTC_ADDR_STATUS 4'h4
// Status write: a one in these bit positions clears the matching flag
`define CTC_CLR_LOW_BIT 0
`define CTC_CLR_HIGH_BIT 1
// ==========================================
// Configuration codes
`define CTC_CODE_STOP 8'h00
`define CTC_CODE_L_SB 8'h05
`define CTC_CODE_H_SW 8'h61
`define CTC_CODE_HSW_LSB 8'h65
`define CTC_CODE_W_SW 8'h68
`define CTC_CODE_H_SB 8'h71
`define CTC_CODE_HSB_LSB 8'h75
`define CTC_CODE_W_SB 8'h7C
`define CTC_CODE_L_AS 8'h85
`define CTC_CODE_HSW_LAS 8'hE5
`define CTC_CODE_HAS 8'hF1
`define CTC_CODE_HAS_LAS 8'hF5
// ==========================================
// Reset values and counts
`define CTC_RST_BYTE 8'h00
`define CTC_AUTOSTOP_ETU 4'hC
`define CTC_ZERO8 8'h00
`define CTC_ZERO16 16'h0000
`define CTC_ZERO24 24'h00_0000
`define CTC_ONE8 8'h01
`define CTC_ONE16 16'h0001
`define CTC_ONE24 24'h00_0001
`define CTC_ONE4 4'h1
`define CTC_ZERO4 4'h0
`endif

/* File: pkg/ctc_pkg.sv */
package ctc_pkg;
    // Per-stage operating mode decoded from the code
    typedef enum logic [2:0]
    {
        CTC_OFF = 3'b000,
        CTC_SW = 3'b001,
        CTC_SB = 3'b010,
        CTC_SB_RELOAD = 3'b011,
        CTC_SB_ASTOP = 3'b100
    } ctc_mode_t;
    // Decoded configuration of the whole counter
    typedef struct packed
    {
        logic wide;
        ctc_mode_t high_mode;
        ctc_mode_t low_mode;
        logic low_astop_rx;
        logic high_astop_rx;
    } ctc_cfg_t;
    // Event inputs from the UART side
    typedef struct packed
    {
        logic etu_tick;
        logic start_bit;
        logic receive_direction;
        logic card_active;
    } ctc_evt_t;
endpackage

/* File: rtl/ctc_astop.sv */
`timescale 1ns/1ps
`include "ctc_cfg.svh"
// ==========================================
// Twelve-ETU auto-stop window after the first received start bit
module ctc_astop
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic arm_i,
    input wire logic start_i,
    input wire logic tick_i,
    // Result
    output logic expire_o
);
    logic [3:0] cnt_reg;
    logic run_reg;
    logic done_reg;
    // Counts ETUs once the first start bit opens the window
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !arm_i)
        begin
            cnt_reg <= `CTC_ZERO4;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (start_i && !run_reg && !done_reg)
        begin
            run_reg <= 1'b1;
            cnt_reg <= `CTC_ZERO4;
        end
        else if (run_reg && tick_i)
        begin
            cnt_reg <= cnt_reg + `CTC_ONE4;
            if (cnt_reg == `CTC_AUTOSTOP_ETU - `CTC_ONE4)
            begin
                run_reg <= 1'b0;
                done_reg <= 1'b1;
            end
        end
    end
    // One-cycle expiry pulse at the end of the 12th ETU
    assign expire_o = run_reg && tick_i && (cnt_reg == `CTC_AUTOSTOP_ETU - `CTC_ONE4);
endmodule // ctc_astop

/* File: verif/ctc_uart_model.sv */
`timescale 1ns/1ps
// ==========================================
// Card-side event source: ETU ticks and start-bit detects
module ctc_uart_model
(
    // Clock
    input wire logic clk_i,
    // Idle cycles after each pulse, varied by the bench for pacing
    input wire logic [3:0] gap_i,
    // Events
    output logic etu_tick_o,
    output logic start_bit_o
);
    // Lines idle low from time zero
    initial
    begin
        etu_tick_o = 1'b0;
        start_bit_o = 1'b0;
    end
    // One-cycle pulse; the gap keeps events apart through the sync flops
    task automatic pulse(input bit sel);
        @(posedge clk_i);
        #1;
        if (sel)
            etu_tick_o = 1'b1;
        else
            start_bit_o = 1'b1;
        @(posedge clk_i);
        #1;
        etu_tick_o = 1'b0;
        start_bit_o = 1'b0;
        repeat (gap_i) @(posedge clk_i);
    endtask
endmodule // ctc_uart_model

/* File: verif/ctc_top_tb.sv */
`timescale 1ns/1ps
`include "ctc_cfg.svh"
// ==========================================
// Self-checking bench with an integer reference model
module ctc_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic tick;
    logic start;
    logic rx = 1'b0;
    logic active = 1'b1;
    logic low_to;
    logic high_to;
    logic irq;
    logic [3:0] gap = 4'h3;
    int fail_count = 0;
    int check_count = 0;
    int seed = 20284;
    int cycles = 0;
    // Model state: lane modes 0 off, 1 software, 2 start bit, 3 reload, 4 auto-stop
    int hm, lm, hcnt, lcnt, code, rh, rm, rl;
    int aleft = -1;
    bit wide, hrun, lrun, hflag, lflag;
    logic [7:0] codes [12] = '{`CTC_CODE_L_SB, `CTC_CODE_H_SW, `CTC_CODE_HSW_LSB, `CTC_CODE_W_SW,
        `CTC_CODE_H_SB, `CTC_CODE_HSB_LSB, `CTC_CODE_W_SB, `CTC_CODE_L_AS, `CTC_CODE_HSW_LAS,
        `CTC_CODE_HAS, `CTC_CODE_HAS_LAS, 8'h3A};
    // ==========================================
    // Design and far side
    ctc_top ctc_top_i (.CORE_CLK_I(clk), .RESET_I(rst), .BUS_ADDR_I(addr), .BUS_WR_I(wr),
        .BUS_WDATA_I(wdata), .BUS_RDATA_O(rdata), .ETU_TICK_I(tick), .START_BIT_I(start),
        .RECEIVE_DIRECTION_I(rx), .CARD_ACTIVE_I(active), .LOW_TIMEOUT_O(low_to),
        .HIGH_TIMEOUT_O(high_to), .TIMEOUT_IRQ_O(irq));
    ctc_uart_model ctc_uart_model_i (.clk_i(clk), .gap_i(gap), .etu_tick_o(tick), .start_bit_o(start));
    // Clock and hang guard
    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fail_count++;
            end_of_test();
        end
    end
    // ==========================================
    // Model
    function automatic int hload();
        int v;
        v = wide ? (rh << 16) + (rm << 8) + rl : (rh << 8) + rm;
        if (v == 0)
            v = wide ? 32'h0100_0000 : 32'h0001_0000;
        return v;
    endfunction
    // Decode a code; a running software count of the same width is kept
    task automatic m_mode(input logic [7:0] c);
        int t;
        int ohm;
        int olm;
        bit ow;
        ohm = hm;
        olm = lm;
        ow = wide;
        case (c)
            `CTC_CODE_L_SB: t = 12'h003;
            `CTC_CODE_H_SW: t = 12'h010;
            `CTC_CODE_HSW_LSB: t = 12'h013;
            `CTC_CODE_W_SW: t = 12'h110;
            `CTC_CODE_H_SB: t = 12'h020;
            `CTC_CODE_HSB_LSB: t = 12'h023;
            `CTC_CODE_W_SB: t = 12'h120;
            `CTC_CODE_L_AS: t = 12'h004;
            `CTC_CODE_HSW_LAS: t = 12'h014;
            `CTC_CODE_HAS: t = 12'h040;
            `CTC_CODE_HAS_LAS: t = 12'h044;
            default: t = 12'h000;
        endcase
        wide = t[8];
        hm = t[7:4];
        lm = t[3:0];
        if (hm == 1 && !(hrun && ohm == 1 && ow == wide))
        begin
            hcnt = hload();
            hrun = 1;
        end
        if (hm != 1 && (hm != ohm || wide != ow))
            hrun = 0;
        if (lm != olm)
            lrun = 0;
        if (c != code)
            aleft = -1;
        code = c;
    endtask
    // One ETU: the upper lane, wide or 16-bit, stops at terminal count, the low lane reloads
    task automatic m_tick();
        if (hrun)
            hcnt--;
        if (hrun && hcnt == 0)
        begin
            hflag = 1;
            hrun = 0;
        end
        if (lrun)
            lcnt--;
        if (lrun && lcnt == 0)
        begin
            lflag = 1;
            lcnt = rl == 0 ? 256 : rl;
        end
        if (aleft > 0)
            aleft--;
        if (aleft == 0 && hm == 4)
            hrun = 0;
        if (aleft == 0 && lm == 4)
            lrun = 0;
    endtask
    // ==========================================
    // Drivers
    task automatic t_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
        case (a)
            `CTC_ADDR_MODE: m_mode(d);
            `CTC_ADDR_RLD_HIGH: rh = d;
            `CTC_ADDR_RLD_MID: rm = d;
            `CTC_ADDR_RLD_LOW: rl = d;
            `CTC_ADDR_STATUS: {hflag, lflag} = {hflag & ~d[1], lflag & ~d[0]};
            default: ;
        endcase
    endtask
    task automatic t_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        @(posedge clk);
        #1;
        d = rdata;
    endtask
    // Host stops the counter and clears flags before any reload
    task automatic t_setup(input logic [7:0] h, input logic [7:0] m, input logic [7:0] l, input logic [7:0] c);
        t_wr(`CTC_ADDR_MODE, `CTC_CODE_STOP);
        t_wr(`CTC_ADDR_STATUS, 8'h03);
        t_wr(`CTC_ADDR_RLD_HIGH, h);
        t_wr(`CTC_ADDR_RLD_MID, m);
        t_wr(`CTC_ADDR_RLD_LOW, l);
        t_wr(`CTC_ADDR_MODE, c);
    endtask
    task automatic t_ticks(input int n);
        repeat (n)
        begin
            ctc_uart_model_i.pulse(1'b1);
            if (active)
                m_tick();
        end
    endtask
    task automatic t_start();
        ctc_uart_model_i.pulse(1'b0);
        if (hm >= 2)
        begin
            hcnt = hload();
            hrun = 1;
        end
        if (lm >= 3 && !lrun)
        begin
            lcnt = rl == 0 ? 256 : rl;
            lrun = 1;
        end
        if (rx && (hm == 4 || lm == 4) && aleft < 0)
            aleft = 12;
    endtask
    // ==========================================
    // Comparisons and verdict
    task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_bit(input string n, input logic e, input logic g);
        cmp_byte(n, {7'h00, e}, {7'h00, g});
    endtask
    // Wide counts may report on either flag, so lanes are merged there
    task automatic t_check();
        logic [7:0] st;
        repeat (4) @(posedge clk);
        t_rd(`CTC_ADDR_STATUS, st);
        if (wide)
            cmp_byte("status", {6'h00, hrun, hflag}, {6'h00, |st[3:2], |st[1:0]});
        else
            cmp_byte("status", {4'h0, hrun, lrun, hflag, lflag}, st);
        cmp_bit("irq", hflag | lflag, irq);
        cmp_bit("high flag", wide ? hflag : hflag, wide ? high_to | low_to : high_to);
        cmp_bit("low flag", wide ? hflag : lflag, wide ? high_to | low_to : low_to);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial
    begin
        logic [7:0] v;
        int n;
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        // Reset values, read-back and an unmapped place
        for (int a = 0; a < 4; a++)
        begin
            t_rd(a[3:0], v);
            cmp_byte("reset value", `CTC_RST_BYTE, v);
        end
        for (int a = 1; a < 4; a++)
        begin
            n = $random(seed);
            t_wr(a[3:0], n[7:0]);
            t_rd(a[3:0], v);
            cmp_byte("read back", n[7:0], v);
        end
        t_rd(4'hF, v);
        cmp_byte("unmapped", 8'h00, v);
        $display("test registers done");
        // Software 16-bit count, one short then at terminal count
        t_setup(8'h00, 8'h05, 8'h00, `CTC_CODE_H_SW);
        t_ticks(4);
        t_check();
        t_ticks(1);
        t_check();
        // Compatible code keeps the count and is stored
        t_setup(8'h00, 8'h06, 8'h00, `CTC_CODE_H_SW);
        t_ticks(3);
        t_wr(`CTC_ADDR_MODE, `CTC_CODE_HSW_LSB);
        t_rd(`CTC_ADDR_MODE, v);
        cmp_byte("mode", `CTC_CODE_HSW_LSB, v);
        t_ticks(3);
        t_check();
        // 05h stops only the 16-bit part, 00h stops the rest
        t_setup(8'h00, 8'h06, 8'h0D, `CTC_CODE_HSW_LSB);
        t_start();
        t_ticks(2);
        t_wr(`CTC_ADDR_MODE, `CTC_CODE_L_SB);
        t_ticks(8);
        t_check();
        t_wr(`CTC_ADDR_MODE, `CTC_CODE_STOP);
        t_ticks(8);
        t_check();
        // An undefined code written mid-count stops both running parts
        t_setup(8'h00, 8'h06, 8'h0D, `CTC_CODE_HSB_LSB);
        t_start();
        t_ticks(2);
        t_wr(`CTC_ADDR_MODE, 8'h3A);
        t_ticks(8);
        t_check();
        // 24-bit software count of 261
        t_setup(8'h00, 8'h01, 8'h05, `CTC_CODE_W_SW);
        t_ticks(260);
        t_check();
        t_ticks(1);
        t_check();
        $display("test software modes done");
        // Reload written mid-count applies only from the next start bit
        t_setup(8'h00, 8'h06, 8'h00, `CTC_CODE_H_SB);
        t_start();
        t_ticks(3);
        t_wr(`CTC_ADDR_RLD_MID, 8'h0A);
        t_ticks(3);
        t_check();
        t_wr(`CTC_ADDR_STATUS, 8'h03);
        t_start();
        t_ticks(5);
        t_start();
        t_ticks(9);
        t_check();
        t_ticks(1);
        t_check();
        $display("test start bit done");
        // Every code with random reloads, direction, pacing and card state
        foreach (codes[i])
        begin
            n = $random(seed);
            rx = n[4];
            t_setup(8'h00, 8'h04 + {5'h00, n[2:0]}, 8'h0D + {6'h00, n[6:5]}, codes[i]);
            t_start();
            repeat (6)
            begin
                n = $random(seed);
                gap = 4'h3 + {2'h0, n[1:0]};
                active = n[4:2] != 3'h0;
                repeat (2) @(posedge clk);
                t_ticks(1 + n[7:5]);
                if (!rx && active && n[9:8] == 2'h0)
                    t_start();
                t_check();
                active = 1'b1;
            end
        end
        $display("test all codes done");
        end_of_test();
    end
endmodule // ctc_top_tb
